/* File: phx_pkg.sv */
// phx_pkg: constants and carrier types of the extended control register bank.
// assumes a single 50 MHz clock domain; mdio pins are sampled as plain inputs.
package phx_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [4:0]  REG_EXT_A       = 5'h13;
  localparam logic [4:0]  REG_EXT_B       = 5'h14;

  // ----------------------------------------------------------------------
  // extended_control_a fields
  // ----------------------------------------------------------------------
  localparam int          A_NODE          = 15;
  localparam int          A_SPEED_SRC     = 14;
  localparam int          A_REMOTE_FAULT  = 13;
  localparam int          A_BANK_HI       = 12;
  localparam int          A_BANK_LO       = 11;
  localparam int          A_TRISTATE      = 7;
  localparam int          A_AUTO_PD       = 0;
  localparam logic [15:0] A_RESET         = 16'h0201;
  // bits that software may change; node, remote fault and bit 10 stay put
  localparam logic [15:0] A_WR_MASK       = 16'h5BFF;
  localparam logic [1:0]  BANK_LEGACY     = 2'h1;

  // ----------------------------------------------------------------------
  // extended_control_b
  // ----------------------------------------------------------------------
  localparam logic [15:0] B_RESET         = 16'h3FE9;

  // ----------------------------------------------------------------------
  // management frame
  // ----------------------------------------------------------------------
  localparam logic [5:0]  PREAMBLE_ONES   = 6'h20;
  localparam logic [4:0]  HDR_LAST        = 5'h0C;
  localparam logic [4:0]  DATA_LAST       = 5'h11;
  localparam logic [1:0]  OP_READ         = 2'h2;
  localparam logic [1:0]  OP_WRITE        = 2'h1;

  typedef struct packed {
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } phx_acc_s;

  typedef enum logic [2:0] {
    MS_PREAMBLE,
    MS_HEADER,
    MS_READ,
    MS_WRITE
  } phx_mdio_state_e;

endpackage

/* File: phx_mdio_slave.sv */
// phx_mdio_slave: serial management frame engine, one register access per frame.
// assumes mdc and mdio_i synchronous to clk and far slower than clk.
`timescale 1ns/1ps
module phx_mdio_slave (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              mdc,
  input  wire logic              mdio_i,
  output logic                   mdio_o,
  output logic                   mdio_oe,
  input  wire logic [4:0]        phy_addr,
  output logic                   acc_valid,
  output phx_pkg::phx_acc_s      acc,
  input  wire logic [15:0]       rdata
);

  // ----------------------------------------------------------------------
  // mdc edge detect
  // ----------------------------------------------------------------------
  logic                      mdc_q;
  logic                      rise;
  phx_pkg::phx_mdio_state_e  state_q;
  logic [5:0]                ones_q;
  logic [4:0]                cnt_q;
  logic [12:0]               hdr_q;
  logic [15:0]               sh_q;
  logic [13:0]               hdr_full;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mdc_q <= 1'b0;
    end else begin
      mdc_q <= mdc;
    end
  end

  assign rise     = mdc & ~mdc_q;
  assign hdr_full = {hdr_q, mdio_i};

  // ----------------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------------
  // hdr_full: st[13:12] op[11:10] phy[9:5] reg[4:0] (st low bit already in hdr)
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q   <= phx_pkg::MS_PREAMBLE;
      ones_q    <= 6'h00;
      cnt_q     <= 5'h00;
      hdr_q     <= 13'h0000;
      sh_q      <= 16'h0000;
      mdio_o    <= 1'b0;
      mdio_oe   <= 1'b0;
      acc_valid <= 1'b0;
      acc       <= '0;
    end else begin
      acc_valid <= 1'b0;
      if (rise) begin
        unique case (state_q)
          phx_pkg::MS_PREAMBLE: begin
            if (mdio_i) begin
              if (ones_q != phx_pkg::PREAMBLE_ONES) begin
                ones_q <= ones_q + 6'h01;
              end
            end else if (ones_q == phx_pkg::PREAMBLE_ONES) begin
              state_q <= phx_pkg::MS_HEADER;
              cnt_q   <= 5'h00;
              hdr_q   <= 13'h0000;
            end else begin
              ones_q <= 6'h00;
            end
          end
          phx_pkg::MS_HEADER: begin
            hdr_q <= hdr_full[12:0];
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == phx_pkg::HDR_LAST) begin
              cnt_q     <= 5'h00;
              ones_q    <= 6'h00;
              acc.addr  <= hdr_full[4:0];
              state_q   <= phx_pkg::MS_PREAMBLE;
              // foreign address or bad start drops the frame quietly
              if (hdr_full[12] && hdr_full[9:5] == phy_addr) begin
                if (hdr_full[11:10] == phx_pkg::OP_READ) begin
                  acc_valid <= 1'b1;
                  acc.wr    <= 1'b0;
                  state_q   <= phx_pkg::MS_READ;
                end else if (hdr_full[11:10] == phx_pkg::OP_WRITE) begin
                  state_q <= phx_pkg::MS_WRITE;
                end
              end
            end
          end
          phx_pkg::MS_READ: begin
            // first edge drives the turnaround zero, then sixteen data bits
            cnt_q   <= cnt_q + 5'h01;
            mdio_oe <= 1'b1;
            if (cnt_q == 5'h00) begin
              mdio_o <= 1'b0;
              sh_q   <= rdata;
            end else if (cnt_q == phx_pkg::DATA_LAST) begin
              mdio_oe <= 1'b0;
              mdio_o  <= 1'b0;
              state_q <= phx_pkg::MS_PREAMBLE;
            end else begin
              mdio_o <= sh_q[15];
              sh_q   <= {sh_q[14:0], 1'b0};
            end
          end
          phx_pkg::MS_WRITE: begin
            cnt_q <= cnt_q + 5'h01;
            sh_q  <= {sh_q[14:0], mdio_i};
            if (cnt_q == phx_pkg::DATA_LAST) begin
              acc_valid <= 1'b1;
              acc.wr    <= 1'b1;
              acc.wdata <= {sh_q[14:0], mdio_i};
              state_q   <= phx_pkg::MS_PREAMBLE;
            end
          end
          default: begin
            state_q <= phx_pkg::MS_PREAMBLE;
          end
        endcase
      end
    end
  end

endmodule

/* File: phx_ext_ctrl_regs.sv */
// phx_ext_ctrl_regs: extended control registers a and b of the 10/100 phy,
// reached over the serial management pins; other addresses, and b while the legacy bank is selected, go to ext_*.
// assumes one 50 MHz clock and synchronous management pins.
//
// Overview of operation
// - node/repeater bit always reads node mode
// - speed from control bit or speed pin
// - bank selector picks standard or legacy map
// - tristate bit floats twisted-pair line drivers
// - auto power-down bit gates 100 section shutdown
`timescale 1ns/1ps
module phx_ext_ctrl_regs (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              mdc,
  input  wire logic              mdio_i,
  output logic                   mdio_o,
  output logic                   mdio_oe,
  input  wire logic [4:0]        phy_addr,
  input  wire logic              remote_fault,
  input  wire logic              basic_speed_sel,
  input  wire logic              speed_pin,
  input  wire logic              energy_absent,
  output logic                   ext_valid,
  output phx_pkg::phx_acc_s      ext_acc,
  output logic                   ext_bank_legacy,
  input  wire logic [15:0]       ext_rdata,
  output logic                   speed_100,
  output logic                   pair_tristate_enable,
  output logic                   tx100_power_down
);

  // ----------------------------------------------------------------------
  // management engine
  // ----------------------------------------------------------------------
  logic               acc_valid;
  phx_pkg::phx_acc_s  acc;
  logic [15:0]        rdata;
  logic [15:0]        ctrl_a_q;
  logic [15:0]        ctrl_b_q;
  logic               legacy;
  logic               hit_a;
  logic               hit_b;

  phx_mdio_slave u_mdio (
    .clk       (clk),
    .reset_n   (reset_n),
    .mdc       (mdc),
    .mdio_i    (mdio_i),
    .mdio_o    (mdio_o),
    .mdio_oe   (mdio_oe),
    .phy_addr  (phy_addr),
    .acc_valid (acc_valid),
    .acc       (acc),
    .rdata     (rdata)
  );

  // ----------------------------------------------------------------------
  // bank decode
  // ----------------------------------------------------------------------
  // only code 01 selects the legacy bank; 1x aliases bank 0
  assign legacy = ctrl_a_q[phx_pkg::A_BANK_HI:phx_pkg::A_BANK_LO] == phx_pkg::BANK_LEGACY;
  assign hit_a  = acc.addr == phx_pkg::REG_EXT_A;
  assign hit_b  = !legacy && acc.addr == phx_pkg::REG_EXT_B;

  assign ext_valid       = acc_valid && !hit_a && !hit_b;
  assign ext_acc         = acc;
  assign ext_bank_legacy = legacy;

  always_comb begin
    rdata = ext_rdata;
    if (hit_a) begin
      rdata                          = ctrl_a_q;
      rdata[phx_pkg::A_NODE]         = 1'b0;
      rdata[phx_pkg::A_REMOTE_FAULT] = remote_fault;
    end else if (hit_b) begin
      rdata = ctrl_b_q;
    end
  end

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  // reserved bits other than bit 10 of register a are stored as written; readback is not meaningful
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_a_q <= phx_pkg::A_RESET;
    end else if (acc_valid && acc.wr && hit_a) begin
      // repeater request is dropped, node mode stays
      ctrl_a_q <= (acc.wdata & phx_pkg::A_WR_MASK) | (ctrl_a_q & ~phx_pkg::A_WR_MASK);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_b_q <= phx_pkg::B_RESET;
    end else if (acc_valid && acc.wr && hit_b) begin
      ctrl_b_q <= acc.wdata;
    end
  end

  // ----------------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------------
  // registered so the line side never sees a decode glitch
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      speed_100            <= 1'b0;
      pair_tristate_enable <= 1'b0;
      tx100_power_down     <= 1'b0;
    end else begin
      speed_100            <= ctrl_a_q[phx_pkg::A_SPEED_SRC] ? speed_pin : basic_speed_sel;
      pair_tristate_enable <= ctrl_a_q[phx_pkg::A_TRISTATE];
      tx100_power_down     <= ctrl_a_q[phx_pkg::A_AUTO_PD] & energy_absent;
    end
  end

endmodule

/* File: phx_ext_ctrl_regs_properties.sv */
// checker for the extended control registers, port-level relations only.
// assumes binding onto phx_ext_ctrl_regs, one clock domain.
`timescale 1ns/1ps
module phx_ext_ctrl_regs_properties (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic mdio_oe,
  input wire logic basic_speed_sel,
  input wire logic speed_pin,
  input wire logic energy_absent,
  input wire logic ext_valid,
  input wire logic ext_bank_legacy,
  input wire logic speed_100,
  input wire logic pair_tristate_enable,
  input wire logic tx100_power_down
);
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_PD_CAUSE: assert property (tx100_power_down |-> $past(energy_absent))
    else $error("power down without energy absent");
  AST_PD_ENERGY: assert property ($fell(energy_absent) |=> !tx100_power_down)
    else $error("power down held after energy returned");
  AST_SPEED_AGREE: assert property (
    $past(reset_n) && $past(basic_speed_sel) == $past(speed_pin)
    |-> speed_100 == $past(speed_pin))
    else $error("speed differs from both sources");
  AST_SPEED_SRC: assert property (speed_100 |-> $past(basic_speed_sel) || $past(speed_pin))
    else $error("speed high with both sources low");
  AST_EXT_SINGLE: assert property (ext_valid |=> !ext_valid)
    else $error("ext access strobe longer than one cycle");
  AST_BANK_HOLD: assert property (mdio_oe |-> $stable(ext_bank_legacy))
    else $error("bank changed during a read");
  AST_TRI_HOLD: assert property (mdio_oe |-> $stable(pair_tristate_enable))
    else $error("tristate changed during a read");
endmodule

/* File: phx_sta_model.sv */
// station management model: drives one mdio frame per call.
// assumes the bench resolves the mdio wire with a pull-up.
`timescale 1ns/1ps
module phx_sta_model (
  input  wire logic clk,
  input  wire logic mdio,
  output logic      mdc,
  output logic      m_oe,
  output logic      m_out
);
  // ----------------------------------------------------------------------
  // frame driver
  // ----------------------------------------------------------------------
  // mdc idles low between frames; changes ride the falling clk edge
  initial begin
    mdc = 1'b0;
    m_oe = 1'b0;
    m_out = 1'b0;
  end
  task automatic frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rq);
    logic [63:0] v;
    v = {32'hFFFF_FFFF, 2'h1, rd ? 2'h2 : 2'h1, pa, ra, 2'h2, wd};
    rq = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      m_oe = !(rd && i < 18);
      m_out = v[i];
      mdc = 1'b0;
      repeat (4) @(negedge clk);
      mdc = 1'b1;
      if (i < 16) rq[i] = mdio;
      repeat (4) @(negedge clk);
    end
    mdc = 1'b0;
    m_oe = 1'b0;
  endtask
endmodule

/* File: phx_ext_ctrl_regs_bench.sv */
// bench for phx_ext_ctrl_regs: register frames and pin checks.
// assumes phx_sta_model and the checker compiled before this file.
`timescale 1ns/1ps
module phx_ext_ctrl_regs_bench;
  localparam logic [4:0]  PA  = 5'h05;
  localparam logic [15:0] EXT = 16'hA5C3;
  logic clk, reset_n, mdc, m_oe, m_out, mdio_o, mdio_oe, rf, bss, spin, ea;
  logic ext_valid, ext_bank_legacy, speed_100, pair_tristate_enable, tx100_power_down;
  logic [15:0] rd;
  phx_pkg::phx_acc_s ext_acc;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [15:0] ext_hits = 16'h0000;
  // released line reads high through the pull-up
  wire mdio = mdio_oe ? mdio_o : (m_oe ? m_out : 1'b1);
  phx_ext_ctrl_regs dut (.clk(clk), .reset_n(reset_n), .mdc(mdc), .mdio_i(mdio),
    .mdio_o(mdio_o), .mdio_oe(mdio_oe), .phy_addr(PA), .remote_fault(rf),
    .basic_speed_sel(bss), .speed_pin(spin), .energy_absent(ea), .ext_valid(ext_valid),
    .ext_acc(ext_acc), .ext_bank_legacy(ext_bank_legacy), .ext_rdata(EXT),
    .speed_100(speed_100), .pair_tristate_enable(pair_tristate_enable),
    .tx100_power_down(tx100_power_down));
  phx_sta_model sta (.clk(clk), .mdio(mdio), .mdc(mdc), .m_oe(m_oe), .m_out(m_out));
  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    sta.frame(1'b0, PA, ra, d, rd);
  endtask
  task automatic rchk(input logic [4:0] ra, input logic [15:0] exp);
    sta.frame(1'b1, PA, ra, 16'h0000, rd);
    chk16(rd, exp);
  endtask
  task automatic stop_test();
    $display("checks=%0d bad=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // clock, timeout, tests
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // about 28 frames of 512 cycles each, ceiling well above
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ext_valid === 1'b1) begin
      ext_hits <= ext_hits + 16'h0001;
    end
    if (cyc == 30000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    {reset_n, rf, bss, spin, ea} = 5'h00;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    rchk(5'h13, 16'h0201);
    rchk(5'h14, 16'h3FE9);
    chk1(pair_tristate_enable, 1'b0);
    $display("test defaults done");
    {rf, spin, ea} = 3'h7;
    wr(5'h13, 16'hC281);
    rchk(5'h13, 16'h6281);
    chk1(pair_tristate_enable, 1'b1);
    chk1(speed_100, 1'b1);
    {spin, bss} = 2'h1;
    repeat (3) @(negedge clk);
    chk1(speed_100, 1'b0);
    chk1(tx100_power_down, 1'b1);
    wr(5'h13, 16'h0200);
    chk1(speed_100, 1'b1);
    chk1(tx100_power_down, 1'b0);
    chk1(pair_tristate_enable, 1'b0);
    $display("test control done");
    rf = 1'b0;
    for (int c = 0; c < 4; c++) begin
      wr(5'h13, {3'h0, 2'(c), 11'h200});
      chk1(ext_bank_legacy, c == 1);
      rchk(5'h14, (c == 1) ? EXT : 16'h3FE9);
      rchk(5'h13, {3'h0, 2'(c), 11'h200});
    end
    wr(5'h13, 16'h0A00);
    wr(5'h14, 16'h1234);
    chk16({10'h000, ext_acc.wr, ext_acc.addr}, 16'h0034);
    chk16(ext_acc.wdata, 16'h1234);
    chk16(ext_hits, 16'h0002);
    wr(5'h13, 16'h0201);
    rchk(5'h14, 16'h3FE9);
    rchk(5'h1F, EXT);
    chk16(ext_hits, 16'h0003);
    wr(5'h14, 16'hBFD2);
    rchk(5'h14, 16'hBFD2);
    sta.frame(1'b0, 5'h06, 5'h13, 16'h0280, rd);
    rchk(5'h13, 16'h0201);
    chk1(pair_tristate_enable, 1'b0);
    ea = 1'b0;
    $display("test banks done");
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    rchk(5'h13, 16'h0201);
    rchk(5'h14, 16'h3FE9);
    $display("test reset done");
    stop_test();
  end
endmodule
bind phx_ext_ctrl_regs phx_ext_ctrl_regs_properties chk (.clk(clk), .reset_n(reset_n),
  .mdio_oe(mdio_oe), .basic_speed_sel(basic_speed_sel), .speed_pin(speed_pin),
  .energy_absent(energy_absent), .ext_valid(ext_valid), .ext_bank_legacy(ext_bank_legacy),
  .speed_100(speed_100), .pair_tristate_enable(pair_tristate_enable),
  .tx100_power_down(tx100_power_down));
